// ==== bmx_pkg.sv ====
// Package of opcodes, widths and state codes for the branch and move unit
package bmx_pkg;
  localparam logic [7:0] BMX_OP_JC = 8'h40;
  localparam logic [7:0] BMX_OP_JIND = 8'h73;
  localparam logic [7:0] BMX_OP_JBCLR = 8'h30;
  localparam logic [7:0] BMX_OP_JNC = 8'h50;
  localparam logic [7:0] BMX_OP_JNZ = 8'h70;
  localparam logic [7:0] BMX_OP_JZ = 8'h60;
  localparam logic [7:0] BMX_OP_LONG_CALL = 8'h12;
  localparam logic [7:0] BMX_OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] BMX_OP_LDDP = 8'h90;
  localparam logic [7:0] BMX_OP_CFDP = 8'h93;
  localparam logic [7:0] BMX_OP_CFPC = 8'h83;
  localparam logic [4:0] BMX_OP_ABANK = 5'h1d;
  localparam logic [6:0] BMX_OP_STIND = 7'h7b;
  localparam logic [15:0] BMX_LEN1 = 16'h0001;
  localparam logic [15:0] BMX_LEN2 = 16'h0002;
  localparam logic [15:0] BMX_LEN3 = 16'h0003;
  localparam logic [7:0] BMX_ONE8 = 8'h01;
  localparam logic [7:0] BMX_ZERO8 = 8'h00;
  localparam logic [2:0] BMX_BANK_BITS = 3'h7;

  typedef enum logic [4:0]
  {
    BMX_IDLE = 5'b00001,
    BMX_EXEC = 5'b00010,
    BMX_PUSH_HI = 5'b00100,
    BMX_CODE_RD = 5'b01000,
    BMX_DONE = 5'b10000
  } bmx_state_t;
endpackage : bmx_pkg

// ==== bmx_stack_ram.sv ====
// Small internal data RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module bmx_stack_ram
(
  input wire logic clk_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [7:0] waddr_i, // Write address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic [7:0] raddr_i, // Read address
  output logic [7:0] rdata_o // Registered read data
);
  logic [7:0] mem_r [0:255];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule : bmx_stack_ram
`default_nettype wire

// ==== bmx_branch_move.sv ====
// Execute unit for branches, calls, byte copies and code table reads
// Overview of operation
// - Carry jump: advance two, branch if set
// - Indirect jump loads acc plus pointer
// - Bit-clear jump: advance three, branch if zero
// - No-carry jump: advance two, branch if clear
// - Nonzero jump branches when accumulator nonzero
// - Zero jump branches when accumulator zero
// - Long call pushes pc+3 low then high
// - Long call loads sixteen-bit target in the low-push cycle
// - Long jump loads sixteen-bit target, no flags
// - Byte copy leaves source and flags unchanged
// - Acc from bank register: one byte, cycle
// - Load data pointer high then low
// - Code load from acc plus base
// - Pointer-based code load, full carry sum
// - Pc-based code load advances pc first
`timescale 1ns/1ps
`default_nettype none
module bmx_branch_move
  import bmx_pkg::*;
(
  input wire logic clk_i, // 20 MHz clock
  input wire logic sys_rst_i, // Sync reset, active high
  input wire logic start_i, // Instruction valid pulse
  input wire logic [7:0] op_i, // Opcode byte
  input wire logic [7:0] b2_i, // Second instruction byte
  input wire logic [7:0] b3_i, // Third instruction byte
  input wire logic [15:0] pc_i, // Address of the opcode
  input wire logic [7:0] acc_i, // Accumulator
  input wire logic [15:0] data_pointer_i, // Data pointer
  input wire logic [7:0] sp_i, // Stack pointer
  input wire logic carry_i, // Carry flag
  input wire logic bit_i, // Addressed bit value
  input wire logic [63:0] bank_i, // Eight bank registers
  input wire logic [7:0] code_data_i, // Program memory read data
  output logic done_o, // One-cycle completion pulse
  output logic [15:0] pc_o, // Next program counter
  output logic [7:0] acc_o, // Accumulator result
  output logic acc_we_o, // Accumulator write enable
  output logic [15:0] data_pointer_o, // Data pointer result
  output logic data_pointer_we_o, // Data pointer write enable
  output logic [7:0] sp_o, // Stack pointer result
  output logic code_rd_o, // Program memory read strobe
  output logic [15:0] code_addr_o, // Program memory address
  output logic ram_we_o, // Data RAM write strobe
  output logic [7:0] ram_addr_o, // Data RAM address
  output logic [7:0] ram_wdata_o, // Data RAM write data
  output logic [7:0] stack_rdata_o // Registered RAM read data
);
  typedef struct packed
  {
    bmx_state_t st;
    logic done;
    logic [15:0] pc;
    logic [7:0] acc;
    logic acc_we;
    logic [15:0] data_pointer;
    logic data_pointer_we;
    logic [7:0] sp;
    logic code_rd;
    logic [15:0] code_addr;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] hi_byte;
  } bmx_regs_t;

  bmx_regs_t s_r;
  bmx_regs_t s_nxt;

  // Sign-extended relative target
  function automatic logic [15:0] rel_target(input logic [15:0] base,
                                             input logic [7:0] rel);
    rel_target = base + {{8{rel[7]}}, rel};
  endfunction : rel_target

  // Fall through or branch
  function automatic logic [15:0] cond_pc(input logic [15:0] adv,
                                          input logic [7:0] rel,
                                          input logic take);
    cond_pc = take ? rel_target(adv, rel) : adv;
  endfunction : cond_pc

  logic [15:0] pc2;
  logic [15:0] pc3;
  logic [15:0] pc1;
  assign pc1 = pc_i + BMX_LEN1;
  assign pc2 = pc_i + BMX_LEN2;
  assign pc3 = pc_i + BMX_LEN3;

  // ==================================================================
  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.acc_we = 1'b0;
    s_nxt.data_pointer_we = 1'b0;
    s_nxt.ram_we = 1'b0;
    s_nxt.code_rd = 1'b0;
    unique case (s_r.st)
      BMX_IDLE:
      begin
        if (start_i)
        begin
          s_nxt.st = BMX_EXEC;
          s_nxt.pc = pc1;
          if (op_i == BMX_OP_JC)
          begin
            s_nxt.pc = cond_pc(pc2, b2_i, carry_i);
          end
          else if (op_i == BMX_OP_JNC)
          begin
            s_nxt.pc = cond_pc(pc2, b2_i, !carry_i);
          end
          else if (op_i == BMX_OP_JNZ)
          begin
            s_nxt.pc = cond_pc(pc2, b2_i, |acc_i);
          end
          else if (op_i == BMX_OP_JZ)
          begin
            s_nxt.pc = cond_pc(pc2, b2_i, ~|acc_i);
          end
          else if (op_i == BMX_OP_JBCLR)
          begin
            s_nxt.pc = cond_pc(pc3, b3_i, !bit_i);
          end
          else if (op_i == BMX_OP_JIND)
          begin
            s_nxt.pc = {BMX_ZERO8, acc_i} + data_pointer_i;
          end
          else if (op_i == BMX_OP_LONG_JUMP)
          begin
            s_nxt.pc = {b2_i, b3_i};
          end
          else if (op_i == BMX_OP_LONG_CALL)
          begin
            s_nxt.sp = sp_i + BMX_ONE8;
            s_nxt.ram_we = 1'b1;
            s_nxt.ram_addr = sp_i + BMX_ONE8;
            s_nxt.ram_wdata = pc3[7:0];
            s_nxt.hi_byte = pc3[15:8];
            s_nxt.pc = {b2_i, b3_i};
            s_nxt.st = BMX_PUSH_HI;
          end
          else if (op_i == BMX_OP_LDDP)
          begin
            s_nxt.pc = pc3;
            s_nxt.data_pointer = {b2_i, b3_i};
            s_nxt.data_pointer_we = 1'b1;
          end
          else if (op_i == BMX_OP_CFDP)
          begin
            s_nxt.code_addr = {BMX_ZERO8, acc_i} + data_pointer_i;
            s_nxt.code_rd = 1'b1;
            s_nxt.st = BMX_CODE_RD;
          end
          else if (op_i == BMX_OP_CFPC)
          begin
            s_nxt.code_addr = {BMX_ZERO8, acc_i} + pc1;
            s_nxt.code_rd = 1'b1;
            s_nxt.st = BMX_CODE_RD;
          end
          else if (op_i[7:3] == BMX_OP_ABANK)
          begin
            // Accumulator loads and pc advances by one; single cycle
            s_nxt.acc = bank_i[{op_i[2:0] & BMX_BANK_BITS, 3'h0} +: 8];
            s_nxt.acc_we = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = BMX_IDLE;
          end
          else if (op_i[7:1] == BMX_OP_STIND)
          begin
            s_nxt.ram_addr = bank_i[{2'h0, op_i[0], 3'h0} +: 8];
            s_nxt.ram_wdata = acc_i;
            s_nxt.ram_we = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = BMX_IDLE;
          end
        end
      end
      BMX_EXEC:
      begin
        s_nxt.done = 1'b1;
        s_nxt.st = BMX_IDLE;
      end
      BMX_PUSH_HI:
      begin
        s_nxt.sp = s_r.sp + BMX_ONE8;
        s_nxt.ram_addr = s_r.sp + BMX_ONE8;
        s_nxt.ram_wdata = s_r.hi_byte;
        s_nxt.ram_we = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.st = BMX_IDLE;
      end
      BMX_CODE_RD:
      begin
        s_nxt.st = BMX_DONE;
      end
      BMX_DONE:
      begin
        s_nxt.acc = code_data_i;
        s_nxt.acc_we = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.st = BMX_IDLE;
      end
      default:
      begin
        s_nxt.st = BMX_IDLE;
      end
    endcase
  end

  // ==================================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_r <= '0;
      s_r.st <= BMX_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==================================================================
  // Stack RAM
  bmx_stack_ram u_ram
  (
    .clk_i(clk_i),
    .we_i(s_r.ram_we),
    .waddr_i(s_r.ram_addr),
    .wdata_i(s_r.ram_wdata),
    .raddr_i(s_r.ram_addr),
    .rdata_o(stack_rdata_o)
  );

  assign done_o = s_r.done;
  assign pc_o = s_r.pc;
  assign acc_o = s_r.acc;
  assign acc_we_o = s_r.acc_we;
  assign data_pointer_o = s_r.data_pointer;
  assign data_pointer_we_o = s_r.data_pointer_we;
  assign sp_o = s_r.sp;
  assign code_rd_o = s_r.code_rd;
  assign code_addr_o = s_r.code_addr;
  assign ram_we_o = s_r.ram_we;
  assign ram_addr_o = s_r.ram_addr;
  assign ram_wdata_o = s_r.ram_wdata;

  // ==================================================================
  // Checks
  // Helper copies for checks
  logic [15:0] pc2_q;
  logic [15:0] pc3_q;
  logic [15:0] pc3_q2;
  logic [7:0] sp_q1;
  logic [7:0] sp_q2;
  logic [7:0] b2_q;
  logic [7:0] b3_q;
  always_ff @(posedge clk_i)
  begin
    pc2_q <= pc2;
    pc3_q <= pc3;
    pc3_q2 <= pc3_q;
    sp_q1 <= sp_i;
    sp_q2 <= sp_q1;
    b2_q <= b2_i;
    b3_q <= b3_i;
  end

  chk_jc_taken: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JC && carry_i)
    |=> s_r.pc == pc2_q + {{8{b2_q[7]}}, b2_q})
    else $error("carry jump target wrong");
  chk_jind_sum: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JIND)
    |=> s_r.pc == $past(data_pointer_i) + {8'h00, $past(acc_i)} && !s_r.acc_we)
    else $error("indirect jump wrong");
  chk_jnb_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JBCLR && bit_i)
    |=> s_r.pc == $past(pc_i) + 16'h0003)
    else $error("bit jump fall-through wrong");
  chk_jnc_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JNC && carry_i)
    |=> s_r.pc == $past(pc_i) + 16'h0002 ##1 s_r.done)
    else $error("no-carry fall-through wrong");
  chk_jnz_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JNZ)
    |=> !s_r.done ##1 s_r.done && !s_r.acc_we)
    else $error("nonzero jump timing wrong");
  chk_jz_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_JZ && acc_i != 8'h00)
    |=> s_r.pc == $past(pc_i) + 16'h0002)
    else $error("zero jump fall-through wrong");
  chk_call_push: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_LONG_CALL)
    |=> s_r.ram_we && s_r.ram_wdata == pc3_q[7:0] ##1
        s_r.ram_we && s_r.ram_wdata == pc3_q2[15:8] && s_r.sp == sp_q2 + 8'h02)
    else $error("call push wrong");
  chk_long_jump_tgt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_LONG_JUMP)
    |=> s_r.pc == {b2_q, b3_q})
    else $error("long jump target wrong");
  chk_code_fetch_load_dp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_r.st == BMX_IDLE && start_i && op_i == BMX_OP_CFDP)
    |=> s_r.code_rd ##2 s_r.acc_we && s_r.done)
    else $error("code load timing wrong");
endmodule : bmx_branch_move
`default_nettype wire

// ==== bmx_code_mem_model.sv ====
// Program memory model answering the code table reads
`timescale 1ns/1ps
`default_nettype none
module bmx_code_mem_model
(
  input wire logic clk_i, // System clock
  input wire logic rd_i, // Read strobe
  input wire logic [15:0] addr_i, // Read address
  output logic [7:0] data_o // Read data
);
  // ==========
  // Data valid one cycle after the strobe, scrambled at all other times
  initial data_o = 8'h3c;
  always @(posedge clk_i)
  begin
    if (rd_i)
      data_o <= addr_i[15:8] ^ addr_i[7:0] ^ 8'ha5;
    else
      data_o <= ~data_o;
  end
endmodule : bmx_code_mem_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the branch and move unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bmx_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic carry_i = 1'b0;
  logic bit_i = 1'b0;
  logic [7:0] op_i = 8'h00, b2_i = 8'h00, b3_i = 8'h00;
  logic [7:0] acc_i = 8'h00, sp_i = 8'h00;
  logic [15:0] pc_i = 16'h0000, data_pointer_i = 16'h0000;
  logic [63:0] bank_i = 64'h0;
  logic [7:0] code_data, acc_o, sp_o, ram_addr_o, ram_wdata_o, stack_rd;
  logic done_o, acc_we_o, data_pointer_we_o, code_rd_o, ram_we_o;
  logic [15:0] pc_o, data_pointer_o, code_addr_o;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int acc_n, dp_n, rd_n;
  logic [7:0] acc_v;
  logic [15:0] dp_v, rd_a;
  logic [7:0] wa_q[$], wd_q[$];

  bmx_branch_move dut_u
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i),
    .b2_i(b2_i), .b3_i(b3_i), .pc_i(pc_i), .acc_i(acc_i), .data_pointer_i(data_pointer_i),
    .sp_i(sp_i), .carry_i(carry_i), .bit_i(bit_i), .bank_i(bank_i),
    .code_data_i(code_data), .done_o(done_o), .pc_o(pc_o), .acc_o(acc_o),
    .acc_we_o(acc_we_o), .data_pointer_o(data_pointer_o), .data_pointer_we_o(data_pointer_we_o),
    .sp_o(sp_o), .code_rd_o(code_rd_o), .code_addr_o(code_addr_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o), .stack_rdata_o(stack_rd)
  );
  bmx_code_mem_model mem_u
  (
    .clk_i(clk_i), .rd_i(code_rd_o), .addr_i(code_addr_o),
    .data_o(code_data)
  );

  always #25 clk_i = ~clk_i;

  // ==========
  // Pulse collectors and hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (acc_we_o === 1'b1)
    begin
      acc_n++;
      acc_v = acc_o;
    end
    if (data_pointer_we_o === 1'b1)
    begin
      dp_n++;
      dp_v = data_pointer_o;
    end
    if (code_rd_o === 1'b1)
    begin
      rd_n++;
      rd_a = code_addr_o;
    end
    if (ram_we_o === 1'b1)
    begin
      wa_q.push_back(ram_addr_o);
      wd_q.push_back(ram_wdata_o);
    end
    if (cyc == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ==========
  // Checking helpers
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] br(input logic [15:0] len,
                                     input logic [7:0] rel,
                                     input logic take);
    return pc_i + len + (take ? {{8{rel[7]}}, rel} : 16'h0000);
  endfunction : br

  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // ==========
  // One instruction: drive, model, compare
  task automatic run_one(input int k);
    logic [7:0] ops[14];
    logic [7:0] op, ea;
    logic [7:0] wa_e[2], wd_e[2];
    logic [15:0] nx, ca, ret;
    int lat, n, an, dn, wn, rn;
    ops = '{BMX_OP_JC, BMX_OP_JIND, BMX_OP_JBCLR, BMX_OP_JNC, BMX_OP_JNZ,
            BMX_OP_JZ, BMX_OP_LONG_CALL, BMX_OP_LONG_JUMP, BMX_OP_LDDP, BMX_OP_CFDP,
            BMX_OP_CFPC, {BMX_OP_ABANK, 3'h0}, {BMX_OP_STIND, 1'b0}, 8'ha5};
    op = ops[k % 14];
    if (k % 14 == 11)
      op[2:0] = 3'($urandom);
    if (k % 14 == 12)
      op[0] = 1'($urandom);
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= op;
    b2_i <= 8'($urandom);
    b3_i <= 8'($urandom);
    pc_i <= 16'($urandom);
    acc_i <= (k % 3 == 0) ? 8'h00 : 8'($urandom);
    data_pointer_i <= 16'($urandom);
    sp_i <= 8'($urandom);
    carry_i <= 1'($urandom);
    bit_i <= 1'($urandom);
    bank_i <= {$urandom, $urandom};
    acc_n = 0;
    dp_n = 0;
    rd_n = 0;
    wa_q.delete();
    wd_q.delete();
    @(posedge clk_i);
    n = 1;
    if (k % 14 < 9 && k % 5 == 0)
    begin
      @(posedge clk_i);
      n = 2;
    end
    start_i <= 1'b0;
    #1;
    while (done_o !== 1'b1 && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    nx = pc_i + 16'h0001;
    ret = pc_i + 16'h0003;
    lat = 2;
    an = 0;
    dn = 0;
    wn = 0;
    rn = 0;
    ca = {8'h00, acc_i} + data_pointer_i;
    case (op)
      BMX_OP_JC: nx = br(16'h0002, b2_i, carry_i);
      BMX_OP_JIND: nx = ca;
      BMX_OP_JBCLR: nx = br(16'h0003, b3_i, !bit_i);
      BMX_OP_JNC: nx = br(16'h0002, b2_i, !carry_i);
      BMX_OP_JNZ: nx = br(16'h0002, b2_i, acc_i != 8'h00);
      BMX_OP_JZ: nx = br(16'h0002, b2_i, acc_i == 8'h00);
      BMX_OP_LONG_JUMP: nx = {b2_i, b3_i};
      BMX_OP_LDDP:
      begin
        nx = ret;
        dn = 1;
      end
      BMX_OP_LONG_CALL:
      begin
        nx = {b2_i, b3_i};
        wn = 2;
        wa_e = '{sp_i + 8'h01, sp_i + 8'h02};
        wd_e = '{ret[7:0], ret[15:8]};
      end
      BMX_OP_CFDP, BMX_OP_CFPC:
      begin
        if (op == BMX_OP_CFPC)
          ca = pc_i + 16'h0001 + {8'h00, acc_i};
        ea = ca[15:8] ^ ca[7:0] ^ 8'ha5;
        lat = 3;
        an = 1;
        rn = 1;
      end
      default:
      begin
        if (op[7:3] == BMX_OP_ABANK)
        begin
          lat = 1;
          an = 1;
          ea = bank_i[8 * op[2:0] +: 8];
        end
        if (op[7:1] == BMX_OP_STIND)
        begin
          lat = 1;
          wn = 1;
          wa_e[0] = bank_i[8 * op[0] +: 8];
          wd_e[0] = acc_i;
        end
      end
    endcase
    @(posedge clk_i);
    #1;
    chk("latency", 16'(lat), 16'(n));
    chk("pc", nx, pc_o);
    chk("acc_we", 16'(an), 16'(acc_n));
    if (an == 1)
      chk("acc", {8'h00, ea}, {8'h00, acc_v});
    chk("data_pointer_we", 16'(dn), 16'(dp_n));
    if (dn == 1)
      chk("data_pointer", {b2_i, b3_i}, dp_v);
    chk("code_rd", 16'(rn), 16'(rd_n));
    if (rn == 1)
      chk("code_addr", ca, rd_a);
    chk("ram_we", 16'(wn), 16'(wa_q.size()));
    for (int i = 0; i < wn && i < wa_q.size(); i++)
    begin
      chk("ram_addr", {8'h00, wa_e[i]}, {8'h00, wa_q[i]});
      chk("ram_data", {8'h00, wd_e[i]}, {8'h00, wd_q[i]});
    end
    if (op == BMX_OP_LONG_CALL)
    begin
      chk("sp", {8'h00, sp_i + 8'h02}, {8'h00, sp_o});
      // High byte landed at the last edge, read back one edge later
      @(posedge clk_i);
      #1;
      chk("stack_rd", {8'h00, ret[15:8]}, {8'h00, stack_rd});
    end
  endtask : run_one

  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(32'h86130d0e));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("done_rst", 16'h0000, {15'h0000, done_o});
    chk("pc_rst", 16'h0000, pc_o);
    for (int k = 0; k < 280; k++)
      run_one(k);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
